// [hdl/mon_defines.vh]
// Constants of the monitor's register map, control fields and result formats
// Behaviour
// RL1: Control bit 7 selects Celsius or Kelvin
// RL2: Control bit 6 selects repeated or single acquisition
// RL3: Group field picks internal, pair one, two, all
// RL4: Combination field picks the measured input set
// RL5: Control resets to zero: internal, repeated, Celsius
// RL6: Busy reads one throughout repeated acquisition
// RL7: Voltage upper byte: fresh, sign, D13..D8
// RL8: Lower byte carries D7..D0 in order
// RL9: Temperature upper byte: fresh, short, open, D12..D8
// RL10: New result sets the register's fresh flag
// RL11: Host read addressing clears the fresh flag
// RL12: Remote diode: low in1 raises short flag
// RL13: Remote diode: excessive in1 raises open flag
// RL14: Internal temperature never reports short or open
// RL15: Voltage sign plus 14 bits; supply minus 2.5V
// RL16: Temperature 13 bits, Celsius signed, Kelvin unsigned
// RL17: Busy high while single conversion runs
// RL18: Any write to trigger starts a conversion
// RL19: Reserved control bit 5 stored without effect
`ifndef MON_DEFINES_VH
`define MON_DEFINES_VH

// ----------------------------------------------------------------------------
// Register pointer values
// ----------------------------------------------------------------------------
`define MON_REG_STATUS   4'h0
`define MON_REG_CTRL     4'h1
`define MON_REG_TRIG     4'h2
`define MON_REG_UNUSED   4'h3
`define MON_CTRL_RESET   8'h00

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define MON_CTRL_KELVIN  7
`define MON_CTRL_SINGLE  6
`define MON_CTRL_RSVD    5
`define MON_GRP_HI       4
`define MON_GRP_LO       3
`define MON_COMB_HI      2
`define MON_COMB_LO      0

// ----------------------------------------------------------------------------
// Serial addresses (upper five bits of own address, global sync address)
// ----------------------------------------------------------------------------
`define MON_ADDR_BASE    5'h13
`define MON_ADDR_SYNC    7'h77

// ----------------------------------------------------------------------------
// Result formats
// ----------------------------------------------------------------------------
`define MON_KELVIN_OFS   16'h1112
`define MON_VCC_OFS      16'h2000
`define MON_SLOTS        6

// ----------------------------------------------------------------------------
// Measurement selection codes
// ----------------------------------------------------------------------------
`define MON_SEL_ITEMP    4'h0
`define MON_SEL_IN1      4'h1
`define MON_SEL_IN2      4'h2
`define MON_SEL_DIFF12   4'h3
`define MON_SEL_DIODE_A  4'h4
`define MON_SEL_IN3      4'h5
`define MON_SEL_IN4      4'h6
`define MON_SEL_DIFF34   4'h7
`define MON_SEL_DIODE_B  4'h8
`define MON_SEL_VCC      4'h9

`endif

// [hdl/mon_ram.v]
// Result storage with registered read data
`timescale 1ns/100ps
module mon_ram #(
  parameter W  = 15,
  parameter D  = 6,
  parameter AW = 3
) (
  input  wire          clk,    // System clock
  input  wire          we,     // Write strobe
  input  wire [AW-1:0] waddr,  // Write slot
  input  wire [W-1:0]  wdata,  // Write data
  input  wire [AW-1:0] raddr,  // Read slot
  output reg  [W-1:0]  rdata   // Registered read data
);

  reg [W-1:0] mem [0:D-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// [hdl/mon_seq.v]
// Acquisition sequencer: walks the enabled measurement slots
`timescale 1ns/100ps
`include "mon_defines.vh"
module mon_seq (
  input  wire       clk,        // System clock
  input  wire       resetn,     // Asynchronous reset, active low
  input  wire [7:0] ctrl,       // Measurement control byte
  input  wire       trig,       // Trigger pulse
  input  wire       done,       // Measurement finished pulse
  output reg        start_r,    // Measurement start pulse
  output reg  [3:0] sel_r,      // Current measurement selection
  output reg  [2:0] slot_r,     // Current result slot
  output wire       busy        // Conversion in progress
);

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_WAIT = 2'b10;

  reg [1:0] state_r;

  // Pair kinds: 0 single-ended, 1 differential, 2 remote diode
  function [1:0] pair1_kind;
    input [2:0] c;
    begin
      case (c)                                             // RL4
        3'h0, 3'h7:       pair1_kind = 2'h0;
        3'h3, 3'h4, 3'h5: pair1_kind = 2'h2;
        default:          pair1_kind = 2'h1;
      endcase
    end
  endfunction

  function [1:0] pair2_kind;
    input [2:0] c;
    begin
      case (c)                                             // RL4
        3'h2, 3'h3, 3'h7: pair2_kind = 2'h0;
        3'h0, 3'h1, 3'h5: pair2_kind = 2'h2;
        default:          pair2_kind = 2'h1;
      endcase
    end
  endfunction

  function [5:0] slot_mask;
    input [7:0] c;
    reg [1:0] g;
    begin
      g = c[`MON_GRP_HI:`MON_GRP_LO];
      slot_mask[0] = (g == 2'h0) | (g == 2'h3);            // RL3
      slot_mask[1] = g[0];
      slot_mask[2] = g[0] & (pair1_kind(c[2:0]) == 2'h0);
      slot_mask[3] = g[1];
      slot_mask[4] = g[1] & (pair2_kind(c[2:0]) == 2'h0);
      slot_mask[5] = (g == 2'h3);
    end
  endfunction

  function [3:0] slot_sel;
    input [7:0] c;
    input [2:0] s;
    reg [1:0] k1;
    reg [1:0] k2;
    begin
      k1 = pair1_kind(c[2:0]);
      k2 = pair2_kind(c[2:0]);
      case (s)
        3'h1:    slot_sel = (k1 == 2'h0) ? `MON_SEL_IN1 :
                            (k1 == 2'h2) ? `MON_SEL_DIODE_A : `MON_SEL_DIFF12;
        3'h2:    slot_sel = `MON_SEL_IN2;
        3'h3:    slot_sel = (k2 == 2'h0) ? `MON_SEL_IN3 :
                            (k2 == 2'h2) ? `MON_SEL_DIODE_B : `MON_SEL_DIFF34;
        3'h4:    slot_sel = `MON_SEL_IN4;
        3'h5:    slot_sel = `MON_SEL_VCC;
        default: slot_sel = `MON_SEL_ITEMP;
      endcase
    end
  endfunction

  // Lowest enabled slot at or above lo; 7 when none remains
  function [2:0] next_slot;
    input [5:0] m;
    input [3:0] lo;
    integer i;
    begin
      next_slot = 3'h7;
      for (i = 5; i >= 0; i = i - 1) begin
        if (m[i] && (i >= lo)) begin
          next_slot = i[2:0];
        end
      end
    end
  endfunction

  wire [5:0] mask  = slot_mask(ctrl);
  wire [2:0] first = next_slot(mask, 4'h0);
  wire [2:0] after = next_slot(mask, {1'b0, slot_r} + 4'h1);

  assign busy = state_r[1];                                // RL6 RL17

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      start_r <= 1'b0;
      sel_r   <= `MON_SEL_ITEMP;
      slot_r  <= 3'h0;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (trig) begin                                  // RL18
            state_r <= S_WAIT;
            start_r <= 1'b1;
            slot_r  <= first;
            sel_r   <= slot_sel(ctrl, first);
          end
        end
        S_WAIT: begin
          if (trig) begin                                  // RL18
            start_r <= 1'b1;
            slot_r  <= first;
            sel_r   <= slot_sel(ctrl, first);
          end else if (done) begin
            if (after != 3'h7) begin
              start_r <= 1'b1;
              slot_r  <= after;
              sel_r   <= slot_sel(ctrl, after);
            end else if (!ctrl[`MON_CTRL_SINGLE]) begin   // RL2
              start_r <= 1'b1;
              slot_r  <= first;
              sel_r   <= slot_sel(ctrl, first);
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule

// [hdl/mon_top.v]
// Monitor core: serial register slave, result formatting and freshness flags
`timescale 1ns/100ps
`include "mon_defines.vh"
module mon_top #(
  parameter [4:0] ADDR_HI = `MON_ADDR_BASE
) (
  input  wire        clk,           // System clock, 20 MHz
  input  wire        resetn,        // Asynchronous reset, active low
  input  wire        scl_i,         // Serial clock pin
  input  wire        sda_i,         // Serial data pin level
  output wire        sda_o,         // Serial data drive value, always low
  output wire        sda_oe,        // Serial data pull-low enable
  input  wire [1:0]  adr_i,         // Address select pins
  output wire        meas_start,    // Measurement start pulse
  output wire [3:0]  meas_sel,      // Measurement selection
  input  wire        meas_done,     // Measurement done pulse
  input  wire [15:0] meas_code,     // Raw measurement code
  input  wire        meas_in1_low,  // in1 below valid range
  input  wire        meas_in1_high, // in1 excessive
  output wire        conv_busy      // Conversion in progress
);

  // --------------------------------------------------------------------------
  // Serial engine states and byte kinds
  // --------------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_RACK = 5'h10;

  localparam [1:0] K_ADDR  = 2'h0;
  localparam [1:0] K_CMD   = 2'h1;
  localparam [1:0] K_DATA  = 2'h2;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function [2:0] slot_of;
    input [3:0] p;
    begin
      slot_of = p[3:1] - 3'h2;
    end
  endfunction

  function [14:0] fmt_result;
    input [3:0]  sel;
    input [15:0] code;
    input        kel;
    input        lo;
    input        hi;
    reg   [15:0] t;
    reg   [15:0] v;
    begin
      t = kel ? code : code - `MON_KELVIN_OFS;             // RL1 RL16
      v = code - `MON_VCC_OFS;
      case (sel)
        `MON_SEL_ITEMP:   fmt_result = {2'b00, t[12:0]};  // RL14
        `MON_SEL_DIODE_A,
        `MON_SEL_DIODE_B: fmt_result = {lo, hi, t[12:0]}; // RL9 RL12 RL13
        `MON_SEL_VCC:     fmt_result = v[14:0];           // RL15
        default:          fmt_result = code[14:0];        // RL7 RL15
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [2:0] scl_sync_r;
  reg [2:0] sda_sync_r;
  reg [1:0] adr_s1_r;
  reg [1:0] adr_s2_r;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      adr_s1_r   <= 2'h0;
      adr_s2_r   <= 2'h0;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
      adr_s1_r   <= adr_i;
      adr_s2_r   <= adr_s1_r;
    end
  end

  wire scl_h     = scl_sync_r[1];
  wire scl_d     = scl_sync_r[2];
  wire sda_h     = sda_sync_r[1];
  wire sda_d     = sda_sync_r[2];
  wire scl_rise  = scl_h & ~scl_d;
  wire scl_fall  = ~scl_h & scl_d;
  wire start_det = scl_h & scl_d & sda_d & ~sda_h;
  wire stop_det  = scl_h & scl_d & ~sda_d & sda_h;

  // --------------------------------------------------------------------------
  // Registers and shared signals
  // --------------------------------------------------------------------------
  reg  [4:0]  state_r;
  reg  [1:0]  kind_r;
  reg  [7:0]  shift_r;
  reg  [3:0]  bit_cnt_r;
  reg  [3:0]  ptr_r;
  reg         rw_r;
  reg         host_ack_r;
  reg         sda_oe_r;
  reg  [7:0]  ctrl_r;
  reg         trig_r;
  reg         clr_stb_r;
  reg  [2:0]  clr_slot_r;
  reg  [5:0]  fresh_r;
  reg  [5:0]  written_r;
  reg  [7:0]  rd_byte;

  wire        busy;
  wire [2:0]  seq_slot;
  wire [3:0]  seq_sel;
  wire [14:0] ram_q;
  wire [2:0]  rd_slot  = slot_of(ptr_r);
  wire        rd_upper = ~ptr_r[0] & (ptr_r[3:2] != 2'h0);
  wire [7:0]  status   = {1'b0, fresh_r, busy};

  wire addr_hit = (shift_r[7:1] == {ADDR_HI, adr_s2_r}) |
                  ((shift_r[7:1] == `MON_ADDR_SYNC) & ~shift_r[0]);

  assign sda_o     = 1'b0;
  assign sda_oe    = sda_oe_r;
  assign conv_busy = busy;

  // --------------------------------------------------------------------------
  // Acquisition sequencer and result store
  // --------------------------------------------------------------------------
  mon_seq u_seq (
    .clk     (clk),
    .resetn  (resetn),
    .ctrl    (ctrl_r),
    .trig    (trig_r),
    .done    (meas_done),
    .start_r (meas_start),
    .sel_r   (seq_sel),
    .slot_r  (seq_slot),
    .busy    (busy)
  );

  assign meas_sel = seq_sel;

  mon_ram #(
    .W  (15),
    .D  (`MON_SLOTS),
    .AW (3)
  ) u_ram (
    .clk   (clk),
    .we    (meas_done),
    .waddr (seq_slot),
    .wdata (fmt_result(seq_sel, meas_code, ctrl_r[`MON_CTRL_KELVIN],
                       meas_in1_low, meas_in1_high)),
    .raddr (rd_slot),
    .rdata (ram_q)
  );

  // --------------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------------
  always @* begin
    case (ptr_r)
      `MON_REG_STATUS,
      `MON_REG_TRIG:   rd_byte = status;
      `MON_REG_CTRL:   rd_byte = ctrl_r;
      `MON_REG_UNUSED: rd_byte = 8'h00;
      default: begin
        if (!written_r[rd_slot]) begin
          rd_byte = {fresh_r[rd_slot], 7'h00};
        end else if (rd_upper) begin
          rd_byte = {fresh_r[rd_slot], ram_q[14:8]};       // RL7 RL9
        end else begin
          rd_byte = ram_q[7:0];                            // RL8
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Freshness flags: a new result wins over a clear in the same cycle
  // --------------------------------------------------------------------------
  wire [5:0] set_mask = meas_done ? (6'h01 << seq_slot) : 6'h00;
  wire [5:0] clr_mask = clr_stb_r ? (6'h01 << clr_slot_r) : 6'h00;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fresh_r   <= 6'h00;
      written_r <= 6'h00;
    end else begin
      fresh_r   <= (fresh_r & ~clr_mask) | set_mask;     // RL10 RL11
      written_r <= written_r | set_mask;
    end
  end

  // --------------------------------------------------------------------------
  // Serial slave engine
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= ST_IDLE;
      kind_r     <= K_ADDR;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
      ptr_r      <= 4'h0;
      rw_r       <= 1'b0;
      host_ack_r <= 1'b0;
      sda_oe_r   <= 1'b0;
      ctrl_r     <= `MON_CTRL_RESET;                       // RL5
      trig_r     <= 1'b0;
      clr_stb_r  <= 1'b0;
      clr_slot_r <= 3'h0;
    end else begin
      trig_r    <= 1'b0;
      clr_stb_r <= 1'b0;
      if (start_det) begin
        state_r   <= ST_RX;
        kind_r    <= K_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r  <= 1'b0;
      end else if (stop_det) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_h};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && (bit_cnt_r == 4'h8)) begin
              bit_cnt_r <= 4'h0;
              if ((kind_r != K_ADDR) || addr_hit) begin
                state_r  <= ST_ACK;
                sda_oe_r <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
              case (kind_r)
                K_ADDR: rw_r <= shift_r[0];
                K_CMD:  ptr_r <= shift_r[3:0];
                default: begin
                  if (ptr_r == `MON_REG_CTRL) begin
                    ctrl_r <= shift_r;                     // RL19
                  end
                  if (ptr_r == `MON_REG_TRIG) begin
                    trig_r <= 1'b1;                        // RL18
                  end
                  ptr_r <= ptr_r + 4'h1;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if ((kind_r == K_ADDR) && rw_r) begin
                state_r    <= ST_TX;
                shift_r    <= rd_byte;
                sda_oe_r   <= ~rd_byte[7];
                ptr_r      <= ptr_r + 4'h1;
                clr_stb_r  <= rd_upper;                    // RL11
                clr_slot_r <= rd_slot;
              end else begin
                state_r  <= ST_RX;
                sda_oe_r <= 1'b0;
                kind_r   <= (kind_r == K_ADDR) ? K_CMD : K_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == 4'h7) begin
                state_r  <= ST_RACK;
                sda_oe_r <= 1'b0;
              end else begin
                shift_r  <= {shift_r[6:0], 1'b0};
                sda_oe_r <= ~shift_r[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              host_ack_r <= ~sda_h;
            end else if (scl_fall) begin
              if (host_ack_r) begin
                state_r    <= ST_TX;
                bit_cnt_r  <= 4'h0;
                shift_r    <= rd_byte;
                sda_oe_r   <= ~rd_byte[7];
                ptr_r      <= ptr_r + 4'h1;
                clr_stb_r  <= rd_upper;                    // RL11
                clr_slot_r <= rd_slot;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// [tb/mon_host.sv]
// Serial bus host model pacing clock and data toward the monitor
`timescale 1ns/100ps
module mon_host (
  input  logic clk,   // Bench clock pacing the link
  input  logic sda,   // Resolved data line level
  output logic scl,   // Serial clock, idle high
  output logic sda_h  // Host data drive, 1 releases the line
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end

  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Start, or repeated start when the clock sits low
  task automatic start();
    if (scl == 1'b0) begin
      hc(1);
      sda_h = 1'b1;
      hc(3);
      scl = 1'b1;
      hc(4);
    end
    sda_h = 1'b0;
    hc(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    hc(1);
    sda_h = 1'b0;
    hc(3);
    scl = 1'b1;
    hc(4);
    sda_h = 1'b1;
    hc(4);
  endtask

  // Eight data bits then the acknowledge bit, 400 ns each
  task automatic xb(input logic [7:0] tx, input logic ackv, output logic [7:0] rx,
                    output logic ack);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) begin
      hc(1);
      sda_h = (i > 0) ? tx[i-1] : ackv;
      hc(3);
      scl = 1'b1;
      hc(4);
      r[i] = sda;
      scl = 1'b0;
    end
    rx = r[8:1];
    ack = r[0];
  endtask
endmodule

// [tb/mon_top_sva.sv]
// Concurrent checks on the monitor core ports
`timescale 1ns/100ps
module mon_top_sva (
  input logic       clk,        // System clock
  input logic       resetn,     // Asynchronous reset, active low
  input logic       sda_o,      // Serial data drive value
  input logic       sda_oe,     // Serial data pull-low enable
  input logic       meas_start, // Measurement start pulse
  input logic [3:0] meas_sel,   // Measurement selection
  input logic       meas_done,  // Measurement done pulse
  input logic       conv_busy   // Conversion in progress
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // --------------------
  // Sequencer
  // --------------------
  a_start_busy: assert property (meas_start |-> conv_busy)
    else $error("start seen while not busy");
  a_done_next: assert property (meas_done && conv_busy |=> meas_start || !conv_busy)
    else $error("no follow-up after done");
  a_busy_rise: assert property ($rose(conv_busy) |-> meas_start)
    else $error("busy rose without start");
  a_busy_fall: assert property ($fell(conv_busy) |-> $past(meas_done))
    else $error("busy fell without done");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  a_sel_hold: assert property (!meas_start |-> $stable(meas_sel))
    else $error("selection moved between starts");
  a_sel_range: assert property (meas_start |-> meas_sel <= 4'h9)
    else $error("selection code out of range");

  // --------------------
  // Serial data pin
  // --------------------
  a_sda_low: assert property (sda_oe |-> !sda_o)
    else $error("data pin driven high");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("data low too short");

  c_single_end: cover property ($fell(conv_busy));
  c_diode_b: cover property (meas_start && meas_sel == 4'h8);
  c_pull_low: cover property ($rose(sda_oe));
endmodule

bind mon_top mon_top_sva u_sva (
  .clk(clk), .resetn(resetn), .sda_o(sda_o), .sda_oe(sda_oe), .meas_start(meas_start),
  .meas_sel(meas_sel), .meas_done(meas_done), .conv_busy(conv_busy)
);

// [tb/testbench.sv]
// Self-checking bench for the monitor core
`timescale 1ns/100ps
module testbench;
  logic        clk;
  logic        resetn;
  logic        meas_done;
  logic [15:0] meas_code;
  logic        meas_in1_low;
  logic        meas_in1_high;
  wire         scl;
  wire         sda_h;
  wire         sda_o;
  wire         sda_oe;
  wire         meas_start;
  wire  [3:0]  meas_sel;
  wire         conv_busy;
  wire         sda_w = sda_h & ~sda_oe;
  logic [27:0] seen;
  logic [15:0] w;
  logic [35:0] tbl [0:13];
  int          fe_lat;
  int          cnt;
  int          n_errors;
  int          checks_done;

  mon_top dut (
    .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .adr_i(2'h0), .meas_start(meas_start), .meas_sel(meas_sel), .meas_done(meas_done),
    .meas_code(meas_code), .meas_in1_low(meas_in1_low), .meas_in1_high(meas_in1_high),
    .conv_busy(conv_busy)
  );
  mon_host host (.clk(clk), .sda(sda_w), .scl(scl), .sda_h(sda_h));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // --------------------
  // Measurement front end
  // --------------------
  function automatic logic [15:0] code_of(input logic [3:0] s);
    case (s)
      4'h0: code_of = 16'h18A2;
      4'h1: code_of = 16'h7C29;
      4'h4: code_of = 16'h18E2;
      4'h8: code_of = 16'h1112;
      4'h9: code_of = 16'h4CCD;
      default: code_of = {12'h000, s};
    endcase
  endfunction

  always @(posedge clk) begin
    #1;
    meas_done = (meas_start !== 1'b1) && (cnt == 1);
    if (meas_done) begin
      meas_code = code_of(meas_sel);
      meas_in1_low = (meas_sel == 4'h0) || (meas_sel == 4'h4);
      meas_in1_high = (meas_sel == 4'h8);
    end else
      meas_code = ~meas_code;
    if (meas_start === 1'b1) begin
      cnt = fe_lat;
      seen = {seen[23:0], meas_sel};
    end else if (cnt > 0)
      cnt = cnt - 1;
    if (!resetn)
      cnt = 0;
  end

  // --------------------
  // Bench tasks
  // --------------------
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic apply_reset();
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2;
    host.start();
    host.xb(8'h98, 1'b1, r, a0);
    host.xb({4'h0, p}, 1'b1, r, a1);
    host.xb(d, 1'b1, r, a2);
    host.stop();
    chk("write ack", 28'h0, {25'h0, a0, a1, a2});
  endtask

  task automatic rd(input logic [3:0] p, output logic [15:0] v);
    logic [7:0] r;
    logic a;
    host.start();
    host.xb(8'h98, 1'b1, r, a);
    host.xb({4'h0, p}, 1'b1, r, a);
    host.start();
    host.xb(8'h99, 1'b1, r, a);
    host.xb(8'hFF, 1'b0, v[15:8], a);
    host.xb(8'hFF, 1'b1, v[7:0], a);
    host.stop();
  endtask

  // Bounded wait for a done pulse or for the sequencer to go idle
  task automatic wait_for(input logic idle);
    int k;
    for (k = 0; k < 4000; k++) begin
      if (idle ? conv_busy === 1'b0 : meas_done === 1'b1)
        break;
      @(posedge clk);
      #2;
    end
    if (k == 4000) begin
      n_errors++;
      wrap_up();
    end
  endtask

  initial begin
    resetn = 1'b0;
    meas_done = 1'b0;
    meas_code = 16'h0000;
    meas_in1_low = 1'b0;
    meas_in1_high = 1'b0;
    seen = 28'hFFFFFFF;
    fe_lat = 3000;
    cnt = 0;
    n_errors = 0;
    checks_done = 0;
    tbl = '{36'h58FF01289, 36'h59FFF0389, 36'h5AFF03569, 36'h5BFF04569, 36'h5CFFF0479,
            36'h5DFFF0489, 36'h5EFFF0379, 36'h5FF012569, 36'h48FFFFF12, 36'h4EFFFFFF3,
            36'h53FFFFF56, 36'h55FFFFFF8, 36'h47FFFFFF0, 36'h7FF012569};
    apply_reset();
    rd(4'h0, w);
    chk("status and control", 28'h0, {12'h0, w});
    rd(4'h4, w);
    chk("internal result", 28'h0, {12'h0, w});
    wr(4'h2, 8'hA5);
    wait_for(1'b0);
    rd(4'h0, w);
    chk("status", 28'h0300, {12'h0, w});
    rd(4'h4, w);
    chk("internal result", 28'h8790, {12'h0, w});
    rd(4'h4, w);
    chk("internal result", 28'h0790, {12'h0, w});
    chk("repeat sequence", 28'hFFFFF00, seen);
    apply_reset();
    fe_lat = 5;
    for (int i = 0; i < 14; i++) begin
      wr(4'h1, tbl[i][35:28]);
      seen = 28'hFFFFFFF;
      wr(4'h2, i[7:0]);
      wait_for(1'b1);
      chk("slot sequence", tbl[i][27:0], seen);
      rd(4'h1, w);
      chk("control", {20'h0, tbl[i][35:28]}, {20'h0, w[15:8]});
    end
    rd(4'h6, w);
    chk("in1 result", 28'hFC29, {12'h0, w});
    rd(4'hE, w);
    chk("supply result", 28'hACCD, {12'h0, w});
    wr(4'h1, 8'hDD);
    wr(4'h2, 8'h00);
    wait_for(1'b1);
    rd(4'h4, w);
    chk("internal kelvin", 28'h98A2, {12'h0, w});
    rd(4'h6, w);
    chk("diode_a result", 28'hD8E2, {12'h0, w});
    rd(4'hA, w);
    chk("diode_b result", 28'hB112, {12'h0, w});
    wrap_up();
  end
endmodule
